// ### design/bep_pkg.sv
// Package of constants for the blit engine parameter registers.
// Assumes a 16-bit memory-mapped register port and one core clock.
package bep_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets from the drawing register base
  localparam int unsigned REG_CNT  = 7;
  localparam int unsigned REG_W    = 16;
  localparam logic [3:0] OFS_SRC_Y = 4'h0;
  localparam logic [3:0] OFS_SRC_X = 4'h2;
  localparam logic [3:0] OFS_DST_Y = 4'h4;
  localparam logic [3:0] OFS_DST_X = 4'h6;
  localparam logic [3:0] OFS_HGT   = 4'h8;
  localparam logic [3:0] OFS_WID   = 4'hA;
  localparam logic [3:0] OFS_ROP   = 4'hC;

  // Word index of each register (offset / 2)
  localparam logic [2:0] IDX_SRC_Y = 3'h0;
  localparam logic [2:0] IDX_SRC_X = 3'h1;
  localparam logic [2:0] IDX_DST_Y = 3'h2;
  localparam logic [2:0] IDX_DST_X = 3'h3;
  localparam logic [2:0] IDX_HGT   = 3'h4;
  localparam logic [2:0] IDX_WID   = 3'h5;
  localparam logic [2:0] IDX_ROP   = 3'h6;

  // Implemented bits; everything else reads zero
  localparam logic [15:0] MASK_14   = 16'h3FFF;
  localparam logic [15:0] MASK_12   = 16'h0FFF;
  localparam logic [15:0] MASK_ROP  = 16'hFFFF;
  localparam logic [15:0] RESET_VAL = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // Field widths and positions
  localparam int unsigned COORD_W  = 12;
  localparam int unsigned CONST_W  = 14;
  localparam int unsigned ALIGN_W  = 3;
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned ROP_TWO_OP_BIT = 15;
  localparam int unsigned ROP_SRC_BIT    = 14;
  localparam int unsigned MONO_LO_BIT    = 12;
  localparam int unsigned REP_ROT_BIT    = 11;
  localparam int unsigned MATCH_BIT      = 10;
  localparam int unsigned OWNER_BIT      = 9;
  localparam int unsigned TRANS_BIT      = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Command codes, location pattern, pixel formats
  localparam logic [3:0] CMD_RECT_FILL = 4'h1;
  localparam logic [3:0] CMD_STROKE    = 4'h6;
  localparam logic [3:0] CMD_LINE      = 4'h7;
  localparam logic [3:0] CMD_HOST_WR   = 4'h8;
  localparam logic [3:0] CMD_ROT       = 4'hB;
  localparam logic [1:0] LOC_LINEAR    = 2'h3;
  localparam logic [1:0] FMT_8         = 2'h0;
  localparam logic [1:0] FMT_16        = 2'h1;
  localparam logic [1:0] FMT_32        = 2'h2;
  localparam logic [1:0] FMT_24        = 2'h3;

endpackage

// ### design/bep_reg_file.sv
// Small word store for the parameter registers with masked writes.
// Assumes the caller decodes address, lanes and implemented bits.
`timescale 1ns/1ps
module bep_reg_file #(
  parameter int unsigned DEPTH = 7,
  parameter int unsigned WIDTH = 16
) (
  input  logic                    clk_sys,
  input  logic                    reset_n,
  input  logic                    wr_en,
  input  logic [2:0]              wr_idx,
  input  logic [WIDTH-1:0]        wr_data,
  input  logic [WIDTH-1:0]        wr_mask,
  input  logic                    rd_en,
  input  logic [2:0]              rd_idx,
  output logic [WIDTH-1:0]        rd_data_q,
  output logic [DEPTH*WIDTH-1:0]  words
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  //////////////////////////////////////////////////////////////////////////////
  // Masked write; bits outside the mask keep their value
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          mem_q[g] <= bep_pkg::RESET_VAL;
        end else if (wr_en && wr_idx == 3'(g)) begin
          mem_q[g] <= (mem_q[g] & ~wr_mask) | (wr_data & wr_mask);
        end
      end
      assign words[g*WIDTH +: WIDTH] = mem_q[g];
    end
  endgenerate

  // Registered read port; out-of-range index reads zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= (32'(rd_idx) < DEPTH) ? mem_q[rd_idx] : '0;
    end
  end

endmodule // bep_reg_file

// ### design/bep_cmd_decode.sv
// Decodes command code, location format and pixel format into flags.
// Assumes the codes come from the command and format registers.
`timescale 1ns/1ps
module bep_cmd_decode (
  input  logic [3:0] cmd_code,
  input  logic [3:0] loc_format,
  input  logic [1:0] pixel_format_field,
  output logic       is_line,
  output logic       is_stroke,
  output logic       is_host_wr,
  output logic       is_rot,
  output logic       is_fill,
  output logic       linear,
  output logic       fmt_narrow,
  output logic       fmt_24,
  output logic [2:0] bytes_per_pixel
);

  // Command code compares
  assign is_stroke  = (cmd_code == bep_pkg::CMD_STROKE);
  assign is_line    = (cmd_code == bep_pkg::CMD_LINE);
  assign is_host_wr = (cmd_code == bep_pkg::CMD_HOST_WR);
  assign is_rot     = (cmd_code == bep_pkg::CMD_ROT);
  assign is_fill    = (cmd_code == bep_pkg::CMD_RECT_FILL);

  // Low two bits of the pattern are don't-care
  assign linear = (loc_format[3:2] == bep_pkg::LOC_LINEAR);

  // Pixel depth classes
  assign fmt_narrow = (pixel_format_field == bep_pkg::FMT_8) ||
                      (pixel_format_field == bep_pkg::FMT_16);
  assign fmt_24     = (pixel_format_field == bep_pkg::FMT_24);
  assign bytes_per_pixel =
    (pixel_format_field == bep_pkg::FMT_8)  ? 3'h1 :
    (pixel_format_field == bep_pkg::FMT_16) ? 3'h2 :
    (pixel_format_field == bep_pkg::FMT_32) ? 3'h4 : 3'h3;

endmodule // bep_cmd_decode

// ### design/bep_param_regs.sv
// Parameter register block of the 2D drawing engine, with field decode.
// Assumes command, location format, pixel format and clip bounds come
// from neighbouring registers; host writes 16-bit words at fixed offsets.
//
// Summary of operation
// - Location pattern 11xx selects linear addressing
// - Coordinate origin is the top-left pixel
// - Clip against four clip-bound registers
// - Source-Y: Y coordinate or address high
// - Source-X: X coordinate or address low
// - Line draw: source-Y holds diagonal constant
// - Line draw: source-X holds axial step constant
// - Host write: source-X low bits give alignment, zero at 24 bits
// - Destination regs: coordinates or address halves
// - Line draw: destination regs hold start point
// - Height: height, error term, or stroke
// - Width: width, vector length, or stroke
// - Bit 15 picks two-operand raster codes
// - Bit 14 two-operand source, two-op only
// - Mono packing field: none, 8, 16, 32
// - Repeat rotation honoured only for rotation blit
// - Matching-pixel control only with transparency
// - Bit 9 picks source or destination owner
// - Line and fill only at 8/16 bits
// - Command codes 1,6,7,8,B decoded
// - Bit 8 transparency enable, low raster code
// - Pixel format 00/01/10 gives 8/16/32
`timescale 1ns/1ps
module bep_param_regs #(
  parameter int unsigned OFS_W = 8
) (
  input  logic                   clk_sys,
  input  logic                   reset_n,
  // Memory-mapped register port
  input  logic [OFS_W-1:0]       reg_addr,
  input  logic                   reg_wr_en,
  input  logic [1:0]             reg_byte_en,
  input  logic [15:0]            reg_wdata,
  input  logic                   reg_rd_en,
  output logic [15:0]            reg_rdata_q,
  output logic                   reg_rvalid_q,
  // Mode inputs from neighbouring registers
  input  logic [3:0]             engine_cmd_code,
  input  logic [3:0]             format_location,
  input  logic [1:0]             pixel_format_field,
  input  logic [11:0]            clip_left,
  input  logic [11:0]            clip_top,
  input  logic [11:0]            clip_right,
  input  logic [11:0]            clip_bottom,
  // Location outputs
  output logic                   sequential_addressing_q,
  output logic [11:0]            src_x_q,
  output logic [11:0]            src_y_q,
  output logic [23:0]            src_linear_addr_q,
  output logic [11:0]            dst_x_q,
  output logic [11:0]            dst_y_q,
  output logic [23:0]            dst_linear_addr_q,
  output logic                   dst_in_clip_q,
  // Line, stroke and rectangle parameters
  output logic [11:0]            line_start_x_q,
  output logic [11:0]            line_start_y_q,
  output logic [13:0]            axial_step_const_q,
  output logic [13:0]            axial_diag_const_q,
  output logic [13:0]            line_error_term_q,
  output logic [11:0]            vector_length_q,
  output logic [11:0]            stroke_length_q,
  output logic [11:0]            rect_width_q,
  output logic [11:0]            rect_height_q,
  output logic [2:0]             host_mono_align_q,
  // Raster operation controls
  output logic                   rop_two_operand_q,
  output logic                   two_op_src_sel_q,
  output logic [1:0]             mono_pack_sel_q,
  output logic                   repeat_rotation_q,
  output logic                   transparency_en_q,
  output logic                   matching_pixel_ctrl_q,
  output logic                   transparency_owner_sel_q,
  output logic [7:0]             rop_code_q,
  // Depth check and pixel size
  output logic                   cmd_depth_ok_q,
  output logic [2:0]             bytes_per_pixel_q
);

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  localparam int unsigned WORDS = bep_pkg::REG_CNT;
  localparam int unsigned RW    = bep_pkg::REG_W;

  // Implemented-bit mask per word index
  function automatic logic [15:0] field_mask(input logic [2:0] idx);
    case (idx)
      bep_pkg::IDX_SRC_Y: field_mask = bep_pkg::MASK_14;
      bep_pkg::IDX_SRC_X: field_mask = bep_pkg::MASK_14;
      bep_pkg::IDX_DST_Y: field_mask = bep_pkg::MASK_12;
      bep_pkg::IDX_DST_X: field_mask = bep_pkg::MASK_12;
      bep_pkg::IDX_HGT:   field_mask = bep_pkg::MASK_14;
      bep_pkg::IDX_WID:   field_mask = bep_pkg::MASK_12;
      bep_pkg::IDX_ROP:   field_mask = bep_pkg::MASK_ROP;
      default:            field_mask = 16'h0000;
    endcase
  endfunction

  logic [2:0]  acc_idx;
  logic        acc_mapped;
  logic [15:0] lane_mask;
  logic [15:0] wr_mask;

  // Even offsets inside the map only; odd or high offsets are unmapped
  assign acc_idx    = reg_addr[3:1];
  assign acc_mapped = (reg_addr[OFS_W-1:4] == '0) && !reg_addr[0] &&
                      (reg_addr[3:0] <= bep_pkg::OFS_ROP);
  assign lane_mask  = {{8{reg_byte_en[1]}}, {8{reg_byte_en[0]}}};
  // Reserved bits never stored, so they read back zero
  assign wr_mask    = field_mask(acc_idx) & lane_mask;

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [WORDS*RW-1:0] words;
  logic [15:0]         rd_word_q;

  bep_reg_file #(
    .DEPTH (WORDS),
    .WIDTH (RW)
  ) u_store (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .wr_en     (reg_wr_en && acc_mapped),
    .wr_idx    (acc_idx),
    .wr_data   (reg_wdata),
    .wr_mask   (wr_mask),
    .rd_en     (reg_rd_en),
    .rd_idx    (acc_mapped ? acc_idx : 3'h7),
    .rd_data_q (rd_word_q),
    .words     (words)
  );

  // Read answer one cycle after the strobe
  assign reg_rdata_q = rd_word_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Word views
  logic [15:0] w_src_y;
  logic [15:0] w_src_x;
  logic [15:0] w_dst_y;
  logic [15:0] w_dst_x;
  logic [15:0] w_hgt;
  logic [15:0] w_wid;
  logic [15:0] w_rop;

  assign w_src_y = words[32'(bep_pkg::IDX_SRC_Y)*RW +: RW];
  assign w_src_x = words[32'(bep_pkg::IDX_SRC_X)*RW +: RW];
  assign w_dst_y = words[32'(bep_pkg::IDX_DST_Y)*RW +: RW];
  assign w_dst_x = words[32'(bep_pkg::IDX_DST_X)*RW +: RW];
  assign w_hgt   = words[32'(bep_pkg::IDX_HGT)*RW +: RW];
  assign w_wid   = words[32'(bep_pkg::IDX_WID)*RW +: RW];
  assign w_rop   = words[32'(bep_pkg::IDX_ROP)*RW +: RW];

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic       is_line;
  logic       is_stroke;
  logic       is_host_wr;
  logic       is_rot;
  logic       is_fill;
  logic       linear;
  logic       fmt_narrow;
  logic       fmt_24;
  logic [2:0] bpp;

  bep_cmd_decode u_dec (
    .cmd_code           (engine_cmd_code),
    .loc_format         (format_location),
    .pixel_format_field (pixel_format_field),
    .is_line            (is_line),
    .is_stroke          (is_stroke),
    .is_host_wr         (is_host_wr),
    .is_rot             (is_rot),
    .is_fill            (is_fill),
    .linear             (linear),
    .fmt_narrow         (fmt_narrow),
    .fmt_24             (fmt_24),
    .bytes_per_pixel    (bpp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Location selection
  logic        xy_mode;
  logic        blit_dst;
  logic [11:0] src_x_d;
  logic [11:0] src_y_d;
  logic [23:0] src_lin_d;
  logic [11:0] dst_x_d;
  logic [11:0] dst_y_d;
  logic [23:0] dst_lin_d;

  // Line draw reuses the source words, so neither form applies then
  assign xy_mode   = !linear && !is_line;
  assign blit_dst  = !is_line;
  assign src_y_d   = xy_mode ? w_src_y[11:0] : 12'h000;
  assign src_x_d   = xy_mode ? w_src_x[11:0] : 12'h000;
  assign src_lin_d = (linear && !is_line) ? {w_src_y[11:0], w_src_x[11:0]} : 24'h000000;
  assign dst_y_d   = (blit_dst && !linear) ? w_dst_y[11:0] : 12'h000;
  assign dst_x_d   = (blit_dst && !linear) ? w_dst_x[11:0] : 12'h000;
  assign dst_lin_d = (blit_dst && linear) ? {w_dst_y[11:0], w_dst_x[11:0]} : 24'h000000;

  // Inclusive clip box; Y grows downward from the top-left origin
  logic in_clip_d;

  assign in_clip_d = !linear &&
                     (w_dst_x[11:0] >= clip_left) && (w_dst_x[11:0] <= clip_right) &&
                     (w_dst_y[11:0] >= clip_top) && (w_dst_y[11:0] <= clip_bottom);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sequential_addressing_q <= 1'b0;
      src_x_q                 <= 12'h000;
      src_y_q                 <= 12'h000;
      src_linear_addr_q       <= 24'h000000;
      dst_x_q                 <= 12'h000;
      dst_y_q                 <= 12'h000;
      dst_linear_addr_q       <= 24'h000000;
      dst_in_clip_q           <= 1'b0;
    end else begin
      sequential_addressing_q <= linear;
      src_x_q                 <= src_x_d;
      src_y_q                 <= src_y_d;
      src_linear_addr_q       <= src_lin_d;
      dst_x_q                 <= dst_x_d;
      dst_y_q                 <= dst_y_d;
      dst_linear_addr_q       <= dst_lin_d;
      dst_in_clip_q           <= in_clip_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line, stroke and rectangle parameters
  logic [13:0] step_d;
  logic [13:0] diag_d;
  logic [13:0] err_d;
  logic [11:0] vlen_d;
  logic [11:0] stroke_d;
  logic [2:0]  align_d;

  // Constants arrive precomputed; the block only routes them by command
  assign step_d   = is_line ? w_src_x[13:0] : 14'h0000;
  assign diag_d   = is_line ? w_src_y[13:0] : 14'h0000;
  assign err_d    = is_line ? w_hgt[13:0] : 14'h0000;
  assign vlen_d   = is_line ? w_wid[11:0] : 12'h000;
  // Non-horizontal strokes take height, horizontal ones take width
  assign stroke_d = !is_stroke ? 12'h000 :
                    (w_hgt[11:0] != 12'h000) ? w_hgt[11:0] : w_wid[11:0];
  // 24-bit mode leaves alignment to software
  assign align_d  = (is_host_wr && !fmt_24) ? w_src_x[2:0] : 3'h0;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      line_start_x_q     <= 12'h000;
      line_start_y_q     <= 12'h000;
      axial_step_const_q <= 14'h0000;
      axial_diag_const_q <= 14'h0000;
      line_error_term_q  <= 14'h0000;
      vector_length_q    <= 12'h000;
      stroke_length_q    <= 12'h000;
      rect_width_q       <= 12'h000;
      rect_height_q      <= 12'h000;
      host_mono_align_q  <= 3'h0;
    end else begin
      line_start_x_q     <= is_line ? w_dst_x[11:0] : 12'h000;
      line_start_y_q     <= is_line ? w_dst_y[11:0] : 12'h000;
      axial_step_const_q <= step_d;
      axial_diag_const_q <= diag_d;
      line_error_term_q  <= err_d;
      vector_length_q    <= vlen_d;
      stroke_length_q    <= stroke_d;
      rect_width_q       <= (is_line || is_stroke) ? 12'h000 : w_wid[11:0];
      rect_height_q      <= (is_line || is_stroke) ? 12'h000 : w_hgt[11:0];
      host_mono_align_q  <= align_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Raster operation controls
  logic       two_op;
  logic       trans_en;
  logic [7:0] rop_d;

  assign two_op   = w_rop[bep_pkg::ROP_TWO_OP_BIT];
  assign trans_en = w_rop[bep_pkg::TRANS_BIT];
  // Two-operand codes only use the low nibble
  assign rop_d    = two_op ? {4'h0, w_rop[3:0]} : w_rop[7:0];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rop_two_operand_q        <= 1'b0;
      two_op_src_sel_q         <= 1'b0;
      mono_pack_sel_q          <= 2'h0;
      repeat_rotation_q        <= 1'b0;
      transparency_en_q        <= 1'b0;
      matching_pixel_ctrl_q    <= 1'b0;
      transparency_owner_sel_q <= 1'b0;
      rop_code_q               <= 8'h00;
    end else begin
      rop_two_operand_q        <= two_op;
      two_op_src_sel_q         <= two_op && w_rop[bep_pkg::ROP_SRC_BIT];
      mono_pack_sel_q          <= w_rop[bep_pkg::MONO_LO_BIT +: 2];
      repeat_rotation_q        <= is_rot && w_rop[bep_pkg::REP_ROT_BIT];
      transparency_en_q        <= trans_en;
      matching_pixel_ctrl_q    <= trans_en && w_rop[bep_pkg::MATCH_BIT];
      transparency_owner_sel_q <= w_rop[bep_pkg::OWNER_BIT];
      rop_code_q               <= rop_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Depth check: software pre-scales 24-bit values, hardware does not
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cmd_depth_ok_q    <= 1'b0;
      bytes_per_pixel_q <= 3'h0;
    end else begin
      cmd_depth_ok_q    <= !(is_line || is_fill) || fmt_narrow;
      bytes_per_pixel_q <= bpp;
    end
  end

endmodule // bep_param_regs

// ### test/bep_param_regs_checker.sv
// Concurrent checks on the ports of the drawing parameter register block.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
module bep_param_regs_checker #(
  parameter int unsigned OFS_W = 8
) (
  input logic             clk_sys,
  input logic             reset_n,
  input logic [OFS_W-1:0] reg_addr,
  input logic             reg_wr_en,
  input logic [1:0]       reg_byte_en,
  input logic [15:0]      reg_wdata,
  input logic             reg_rd_en,
  input logic [15:0]      reg_rdata_q,
  input logic             reg_rvalid_q,
  input logic [3:0]       engine_cmd_code,
  input logic [3:0]       format_location,
  input logic [1:0]       pixel_format_field,
  input logic             sequential_addressing_q,
  input logic [11:0]      src_x_q,
  input logic [2:0]       host_mono_align_q,
  input logic             rop_two_operand_q,
  input logic             two_op_src_sel_q,
  input logic             repeat_rotation_q,
  input logic             transparency_en_q,
  input logic             matching_pixel_ctrl_q,
  input logic [7:0]       rop_code_q,
  input logic             cmd_depth_ok_q,
  input logic [2:0]       bytes_per_pixel_q
);
  logic armed_q;
  // Skip the first edge after release
  always_ff @(posedge clk_sys) armed_q <= reset_n;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n || !armed_q);
  //////////////////////////////////////////////////////////////////////////////
  // Source-X write, then a quiet X-Y cycle
  sequence s_srcx_wr;
    reg_wr_en && reg_addr == 'h02 && reg_byte_en == 2'b11;
  endsequence
  sequence s_xy_quiet;
    !(reg_wr_en && reg_addr == 'h02) && engine_cmd_code != bep_pkg::CMD_LINE && format_location[3:2] != 2'b11;
  endsequence
  srcx_path_a: assert property (s_srcx_wr ##1 s_xy_quiet |=> src_x_q == $past(reg_wdata[11:0], 2))
    else $error("source X output does not follow the written word");
  unmapped_read_a: assert property (reg_rd_en && (reg_addr[0] || reg_addr > 'h0C)
    |=> reg_rvalid_q && reg_rdata_q == 16'h0000) else $error("unmapped read not zero");
  linear_sel_a: assert property (sequential_addressing_q == ($past(format_location[3:2]) == 2'b11))
    else $error("linear select mismatch");
  two_op_src_a: assert property (two_op_src_sel_q |-> rop_two_operand_q)
    else $error("two-operand source set without two-operand mode");
  match_px_a: assert property (matching_pixel_ctrl_q |-> transparency_en_q)
    else $error("matching pixel control without transparency");
  repeat_rot_a: assert property (repeat_rotation_q |-> $past(engine_cmd_code) == bep_pkg::CMD_ROT)
    else $error("repeat rotation outside rotation blit");
  depth_gate_a: assert property ($past(engine_cmd_code) == bep_pkg::CMD_LINE && $past(pixel_format_field[1])
    |-> !cmd_depth_ok_q) else $error("line accepted at wide depth");
  host_align_a: assert property ($past(engine_cmd_code) != bep_pkg::CMD_HOST_WR |-> host_mono_align_q == 3'h0)
    else $error("alignment outside host write");
  rop2_code_a: assert property (rop_two_operand_q |-> rop_code_q[7:4] == 4'h0)
    else $error("two-operand code has upper bits");
  bpp_32_a: assert property ($past(pixel_format_field) == bep_pkg::FMT_32 |-> bytes_per_pixel_q == 3'h4)
    else $error("32-bit format not four bytes");
endmodule // bep_param_regs_checker

bind bep_param_regs bep_param_regs_checker #(.OFS_W(OFS_W)) u_chk (.clk_sys, .reset_n, .reg_addr, .reg_wr_en,
  .reg_byte_en, .reg_wdata, .reg_rd_en, .reg_rdata_q, .reg_rvalid_q, .engine_cmd_code, .format_location,
  .pixel_format_field, .sequential_addressing_q, .src_x_q, .host_mono_align_q, .rop_two_operand_q, .two_op_src_sel_q,
  .repeat_rotation_q, .transparency_en_q, .matching_pixel_ctrl_q, .rop_code_q, .cmd_depth_ok_q, .bytes_per_pixel_q);

// ### test/testbench.sv
// Self-checking bench for the drawing parameter register block.
// Assumes the bound checker; inputs change on the falling clock edge.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [1:0] reg_byte_en = 2'b00, pixel_format_field = 2'b00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata_q;
  logic [3:0] engine_cmd_code = 4'h0, format_location = 4'h0;
  logic [11:0] clip_left = 12'h100, clip_top = 12'h100, clip_right = 12'h200, clip_bottom = 12'h200;
  logic reg_rvalid_q, sequential_addressing_q, dst_in_clip_q, rop_two_operand_q, two_op_src_sel_q, cmd_depth_ok_q;
  logic repeat_rotation_q, transparency_en_q, matching_pixel_ctrl_q, transparency_owner_sel_q;
  logic [11:0] src_x_q, src_y_q, dst_x_q, dst_y_q, line_start_x_q, line_start_y_q, vector_length_q, stroke_length_q;
  logic [11:0] rect_width_q, rect_height_q;
  logic [23:0] src_linear_addr_q, dst_linear_addr_q;
  logic [13:0] axial_step_const_q, axial_diag_const_q, line_error_term_q;
  logic [2:0] host_mono_align_q, bytes_per_pixel_q;
  logic [1:0] mono_pack_sel_q;
  logic [7:0] rop_code_q;
  logic [15:0] rop_out;
  int failures = 0, num_checks = 0, cycles = 0;
  logic [15:0] mask_t[7] = '{16'h3FFF, 16'h3FFF, 16'h0FFF, 16'h0FFF, 16'h3FFF, 16'h0FFF, 16'hFFFF};
  logic [15:0] rop_in[5] = '{16'hFFFF, 16'h7500, 16'h0600, 16'h82F5, 16'h4BA5};
  logic [15:0] rop_exp[5] = '{16'hFF0F, 16'h3500, 16'h0200, 16'h8205, 16'h0BA5};
  logic [2:0] bpp_exp[4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  // Raster fields in register bit order
  assign rop_out = {rop_two_operand_q, two_op_src_sel_q, mono_pack_sel_q, repeat_rotation_q, matching_pixel_ctrl_q,
                    transparency_owner_sel_q, transparency_en_q, rop_code_q};
  bep_param_regs #(.OFS_W(8)) dut (.clk_sys, .reset_n, .reg_addr, .reg_wr_en, .reg_byte_en, .reg_wdata, .reg_rd_en,
    .reg_rdata_q, .reg_rvalid_q, .engine_cmd_code, .format_location, .pixel_format_field, .clip_left, .clip_top,
    .clip_right, .clip_bottom, .sequential_addressing_q, .src_x_q, .src_y_q, .src_linear_addr_q, .dst_x_q, .dst_y_q,
    .dst_linear_addr_q, .dst_in_clip_q, .line_start_x_q, .line_start_y_q, .axial_step_const_q, .axial_diag_const_q,
    .line_error_term_q, .vector_length_q, .stroke_length_q, .rect_width_q, .rect_height_q, .host_mono_align_q,
    .rop_two_operand_q, .two_op_src_sel_q, .mono_pack_sel_q, .repeat_rotation_q, .transparency_en_q,
    .matching_pixel_ctrl_q, .transparency_owner_sel_q, .rop_code_q, .cmd_depth_ok_q, .bytes_per_pixel_q);
  //////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock and hang ceiling
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_byte_en = be;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask
  // Answer stands one cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    `CHK(reg_rvalid_q, 1'b1)
    `CHK(reg_rdata_q, e)
  endtask
  // Outputs lag one edge
  task automatic settle;
    repeat (2) @(negedge clk_sys);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'(2 * i), 16'h0000);
      wr(8'(2 * i), 16'hFFFF, 2'b11);
      rd(8'(2 * i), mask_t[i]);
    end
    wr(8'h0E, 16'h1234, 2'b11);
    rd(8'h0E, 16'h0000);
    rd(8'h03, 16'h0000);
    wr(8'h0C, 16'h0000, 2'b01);
    rd(8'h0C, 16'hFF00);
    wr(8'h00, 16'h0ABC, 2'b11);
    wr(8'h02, 16'h0123, 2'b11);
    wr(8'h04, 16'h0150, 2'b11);
    wr(8'h06, 16'h0120, 2'b11);
    settle();
    `CHK({rect_height_q, rect_width_q, src_y_q, src_x_q}, 48'hFFFFFFABC123)
    `CHK({dst_y_q, dst_x_q, dst_in_clip_q}, 25'h2A0241)
    clip_right = 12'h11F;
    settle();
    `CHK(dst_in_clip_q, 1'b0)
    format_location = 4'hC;
    settle();
    `CHK({sequential_addressing_q, src_x_q}, 13'h1000)
    `CHK({src_linear_addr_q, dst_linear_addr_q}, 48'hABC123150120)
    format_location = 4'h8;
    engine_cmd_code = 4'h7;
    pixel_format_field = 2'b01;
    wr(8'h00, 16'h2ABC, 2'b11);
    wr(8'h02, 16'h1123, 2'b11);
    wr(8'h08, 16'h3001, 2'b11);
    wr(8'h0A, 16'h0040, 2'b11);
    settle();
    `CHK({axial_diag_const_q, axial_step_const_q}, 28'hAAF1123)
    `CHK({line_error_term_q, vector_length_q}, 26'h3001040)
    `CHK({line_start_y_q, line_start_x_q, src_x_q, cmd_depth_ok_q}, 37'h2A0240001)
    pixel_format_field = 2'b10;
    settle();
    `CHK(cmd_depth_ok_q, 1'b0)
    engine_cmd_code = 4'h6;
    settle();
    `CHK(stroke_length_q, 12'h001)
    wr(8'h08, 16'h0000, 2'b11);
    settle();
    `CHK(stroke_length_q, 12'h040)
    engine_cmd_code = 4'h8;
    settle();
    `CHK(host_mono_align_q, 3'h3)
    pixel_format_field = 2'b11;
    settle();
    `CHK(host_mono_align_q, 3'h0)
    for (int i = 0; i < 4; i++) begin
      pixel_format_field = 2'(i);
      settle();
      `CHK(bytes_per_pixel_q, bpp_exp[i])
    end
    engine_cmd_code = 4'hB;
    for (int i = 0; i < 5; i++) begin
      wr(8'h0C, rop_in[i], 2'b11);
      settle();
      `CHK(rop_out, rop_exp[i])
    end
    engine_cmd_code = 4'h7;
    settle();
    `CHK(rop_out, 16'h03A5)
    engine_cmd_code = 4'h1;
    wr(8'h0A, 16'h00C0, 2'b11);
    settle();
    `CHK({rect_width_q, cmd_depth_ok_q}, 13'h0180)
    print_verdict();
  end
endmodule // testbench
